/* File: tmc_pkg.sv */
// What this block does
// (R1) Waveform mode joins two bits of control B with two bits of control A.
// (R2) Mode 0: plain counting, TOP 0xFFFF, immediate buffer update, overflow at MAX.
// (R3) Modes 1-3: phase-correct, TOP 0x00FF/0x01FF/0x03FF, update at TOP, overflow at BOTTOM.
// (R4) Modes 5-7: fast PWM, 8/9/10-bit TOP, update at BOTTOM, overflow at TOP.
// (R5) Modes 4 and 12: clear on match, TOP compare A or capture, immediate, MAX.
// (R6) Modes 8 and 9: phase-frequency correct, TOP capture or compare A, all at BOTTOM.
// (R7) Modes 10 and 11: phase-correct, TOP capture or compare A, update TOP, overflow BOTTOM.
// (R8) Modes 14 and 15: fast PWM, TOP capture or compare A, update BOTTOM, overflow TOP.
// (R9) Software never selects mode 13; it is reserved.
// (R10) With the filter on, capture input changes after four equal successive samples.
// (R11) Capture on falling edge when edge select is zero, rising when one.
// (R12) A capture copies the count, sets the capture flag, interrupts only if enabled.
// (R13) When capture register is TOP, the capture pin is ignored entirely.
// (R14) Clock select: stop, /1, /8, /64, /256, /1024, external falling, external rising.
// (R15) External count pin is counted even when that pin drives as an output.
// (R16) Force strobes act only in non-PWM modes.
// (R17) A force strobe makes an immediate match using the current output action.
// (R18) A force strobe never raises an interrupt nor clears the counter.
// (R19) Force bits always read as zero.
// (R20) Control B: filter bit 7, edge bit 6, mode high bits 4:3, clock select 2:0.
// (R21) Control C: force A, B, C at bits 7, 6, 5; resets to zero.
// (R22) Low I/O registers answer at offset or offset plus 0x20; extended only in data space.
// (R23) Non-PWM action: 00 disconnected, 01 toggle, 10 clear, 11 set.
// (R24) External count pin is synchronised and each chosen edge gives one count pulse.
package tmc_pkg;
    // Register offsets, unit 1 and unit 3.
    localparam logic [7:0] T1_CTRL_A_OFS = 8'h2F;
    localparam logic [7:0] T1_CTRL_B_OFS = 8'h2E;
    localparam logic [7:0] T1_CTRL_C_OFS = 8'h7A;
    localparam logic [7:0] T3_CTRL_A_OFS = 8'h8B;
    localparam logic [7:0] T3_CTRL_B_OFS = 8'h8A;
    localparam logic [7:0] T3_CTRL_C_OFS = 8'h8C;
    localparam logic [7:0] IO_LOW_LAST = 8'h3F;
    localparam logic [7:0] DATA_SPACE_SHIFT = 8'h20;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Field positions.
    localparam int B_FILTER_BIT = 7;
    localparam int B_EDGE_BIT = 6;
    localparam int B_MODE_HI_LSB = 3;
    localparam int B_CLK_LSB = 0;
    localparam int A_MODE_LO_LSB = 0;
    localparam int A_ACTION_A_LSB = 6;
    localparam int C_FORCE_A_BIT = 7;
    // Counter landmarks.
    localparam logic [15:0] CNT_BOTTOM = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    // Prescaler and filter counts.
    localparam int PRESC_W = 10;
    localparam int FILTER_SAMPLES = 4;
    // Clock select codes.
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // Compare output actions in non-PWM modes.
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
    typedef enum logic [2:0] {
        SEQ_NORMAL = 3'h0,
        SEQ_CLEAR_ON_MATCH = 3'h1,
        SEQ_FAST = 3'h2,
        SEQ_PHASE = 3'h3,
        SEQ_PHASE_FREQ = 3'h4,
        SEQ_RESERVED = 3'h5
    } tmc_seq_t;
    typedef enum logic [2:0] {
        PT_IMMEDIATE = 3'h0,
        PT_TOP = 3'h1,
        PT_BOTTOM = 3'h2,
        PT_MAX = 3'h3,
        PT_NONE = 3'h4
    } tmc_point_t;
    typedef enum logic [1:0] {
        TOP_FIXED = 2'h0,
        TOP_CMP_A = 2'h1,
        TOP_CAPTURE = 2'h2
    } tmc_top_src_t;
endpackage : tmc_pkg

/* File: tmc_ctl_if.sv */
`timescale 1ns/10ps
// Controls and events shared by the mode logic and its helpers.
interface tmc_ctl_if;
    logic [2:0] clk_source_sel;
    logic count_en;
    logic capture_filter_en;
    logic capture_edge_sel;
    logic capture_allow;
    logic capture_trig;
    modport presc (input clk_source_sel, output count_en);
    modport capt (input capture_filter_en, capture_edge_sel, capture_allow, output capture_trig);
    modport ctrl (output clk_source_sel, capture_filter_en, capture_edge_sel, capture_allow,
                  input count_en, capture_trig);
endinterface : tmc_ctl_if

/* File: tmc_prescaler.sv */
`timescale 1ns/10ps
// Count enable source: divided I/O clock or edges of the external count pin.
module tmc_prescaler (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ext_count_pin,
    tmc_ctl_if.presc ctl
);
    logic [tmc_pkg::PRESC_W-1:0] div_ff;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic tick;

    // Free-running divider; each tap is all ones once per its period.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // The pin is read as an input whatever its direction, so software can drive counts. [R15]
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_meta_ff <= ext_count_pin; // [R24]
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    // Edge detection looks only at the second stage and its delayed copy.
    always_comb begin
        unique case (ctl.clk_source_sel) // [R14]
            tmc_pkg::CS_STOP: tick = 1'b0;
            tmc_pkg::CS_DIV1: tick = 1'b1;
            tmc_pkg::CS_DIV8: tick = &div_ff[2:0];
            tmc_pkg::CS_DIV64: tick = &div_ff[5:0];
            tmc_pkg::CS_DIV256: tick = &div_ff[7:0];
            tmc_pkg::CS_DIV1024: tick = &div_ff[9:0];
            tmc_pkg::CS_EXT_FALL: tick = ext_prev_ff & ~ext_sync_ff; // [R24]
            tmc_pkg::CS_EXT_RISE: tick = ~ext_prev_ff & ext_sync_ff; // [R24]
        endcase
    end

    assign ctl.count_en = tick;
endmodule : tmc_prescaler

/* File: tmc_capture_filter.sv */
`timescale 1ns/10ps
// Optional four-sample filter on the capture pin and the selected edge detector.
module tmc_capture_filter #(
    parameter int SAMPLES = tmc_pkg::FILTER_SAMPLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic capture_pin,
    tmc_ctl_if.capt ctl
);
    logic [SAMPLES-1:0] hist_ff;
    logic filt_ff;
    logic prev_ff;
    logic level;

    if (SAMPLES < 2) begin : g_bad
        $error("SAMPLES below 2");
    end

    // Sample history; the filtered level moves only when every sample agrees. [R10]
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hist_ff <= '0;
            filt_ff <= 1'b0;
        end else begin
            hist_ff <= {hist_ff[SAMPLES-2:0], capture_pin};
            if (&hist_ff) begin
                filt_ff <= 1'b1; // [R10]
            end else if (~|hist_ff) begin
                filt_ff <= 1'b0; // [R10]
            end
        end
    end

    // Unfiltered path takes the newest sample, trading noise immunity for latency.
    assign level = ctl.capture_filter_en ? filt_ff : hist_ff[0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    // Pin is disconnected while the capture register serves as TOP. [R13]
    assign ctl.capture_trig = ctl.capture_allow &
        (ctl.capture_edge_sel ? (level & ~prev_ff) : (~level & prev_ff)); // [R11]
endmodule : tmc_capture_filter

/* File: tmc_mode_ctrl.sv */
`timescale 1ns/10ps
// Mode control of one 16-bit timer unit.
module tmc_mode_ctrl #(
    parameter bit UNIT3 = 1'b0
) (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [7:0] IO_ADDR,
    input wire logic IO_SPACE,
    input wire logic IO_WR,
    input wire logic IO_RD,
    input wire logic [7:0] IO_WDATA,
    output logic [7:0] IO_RDATA,
    output logic IO_HIT,
    input wire logic CAPTURE_PIN,
    input wire logic EXT_COUNT_PIN,
    input wire logic [15:0] COUNT_VALUE,
    input wire logic [15:0] COMPARE_A_VALUE,
    input wire logic [2:0] MATCH,
    input wire logic CAPTURE_FLAG_CLR,
    input wire logic CAPTURE_INT_EN,
    output logic COUNT_EN,
    output logic [15:0] TOP_VALUE,
    output logic [2:0] COUNT_SEQ,
    output logic [2:0] BUF_UPDATE_POINT,
    output logic [2:0] OVERFLOW_POINT,
    output logic OVERFLOW_SET,
    output logic COUNTER_CLEAR,
    output logic [15:0] CAPTURE_VALUE,
    output logic CAPTURE_FLAG,
    output logic CAPTURE_IRQ,
    output logic [2:0] COMPARE_OUT,
    output logic [2:0] COMPARE_CONN
);
    localparam logic [7:0] OFS_A = UNIT3 ? tmc_pkg::T3_CTRL_A_OFS : tmc_pkg::T1_CTRL_A_OFS;
    localparam logic [7:0] OFS_B = UNIT3 ? tmc_pkg::T3_CTRL_B_OFS : tmc_pkg::T1_CTRL_B_OFS;
    localparam logic [7:0] OFS_C = UNIT3 ? tmc_pkg::T3_CTRL_C_OFS : tmc_pkg::T1_CTRL_C_OFS;

    tmc_ctl_if ctl ();

    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic [7:0] rdata_ff;
    logic [15:0] capture_ff;
    logic capture_flag_ff;
    logic [15:0] top_ff;
    logic ovf_ff;
    logic clear_ff;
    logic hit_a;
    logic hit_b;
    logic hit_c;
    logic [3:0] waveform_mode_sel;
    tmc_pkg::tmc_seq_t seq;
    tmc_pkg::tmc_point_t upd_pt;
    tmc_pkg::tmc_point_t ovf_pt;
    tmc_pkg::tmc_top_src_t top_src;
    logic [15:0] fixed_top;
    logic [15:0] nxt_top;
    logic non_pwm;
    logic [2:0] force_match;
    logic [15:0] ovf_cmp;

    // Low registers answer both ways; extended ones only in data space.
    function automatic logic addr_hit(input logic [7:0] ofs, input logic [7:0] addr,
                                      input logic io_space);
        logic low;
        low = (ofs <= tmc_pkg::IO_LOW_LAST);
        if (low) begin
            addr_hit = io_space ? (addr == ofs) : (addr == ofs + tmc_pkg::DATA_SPACE_SHIFT); // [R22]
        end else begin
            addr_hit = !io_space && (addr == ofs); // [R22]
        end
    endfunction : addr_hit

    assign hit_a = addr_hit(OFS_A, IO_ADDR, IO_SPACE);
    assign hit_b = addr_hit(OFS_B, IO_ADDR, IO_SPACE);
    assign hit_c = addr_hit(OFS_C, IO_ADDR, IO_SPACE);
    assign IO_HIT = hit_a | hit_b | hit_c;

    // Control A holds all eight bits as written.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_a_ff <= tmc_pkg::CTRL_RESET;
        end else if (IO_WR && hit_a) begin
            ctrl_a_ff <= IO_WDATA;
        end
    end

    // Control B keeps its unused bit 5 at zero so it always reads back zero.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_b_ff <= tmc_pkg::CTRL_RESET;
        end else if (IO_WR && hit_b) begin
            ctrl_b_ff <= IO_WDATA & 8'hDF; // [R20]
        end
    end

    // Read data is registered and valid one clock after the read strobe.
    // Control C has no storage: its force bits are pure strobes.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_ff <= 8'h00;
        end else if (IO_RD) begin
            if (hit_a) begin
                rdata_ff <= ctrl_a_ff;
            end else if (hit_b) begin
                rdata_ff <= ctrl_b_ff;
            end else begin
                rdata_ff <= 8'h00; // [R19] [R21]
            end
        end
    end
    assign IO_RDATA = rdata_ff;

    // Four-bit mode from the two register halves.
    assign waveform_mode_sel = {ctrl_b_ff[tmc_pkg::B_MODE_HI_LSB+1], // [R1]
                                ctrl_b_ff[tmc_pkg::B_MODE_HI_LSB],
                                ctrl_a_ff[tmc_pkg::A_MODE_LO_LSB+1],
                                ctrl_a_ff[tmc_pkg::A_MODE_LO_LSB]};

    // Mode decode; the reserved code is inert so a stray write cannot half-start a mode.
    always_comb begin
        seq = tmc_pkg::SEQ_NORMAL;
        upd_pt = tmc_pkg::PT_IMMEDIATE;
        ovf_pt = tmc_pkg::PT_MAX;
        top_src = tmc_pkg::TOP_FIXED;
        fixed_top = tmc_pkg::CNT_MAX;
        unique case (waveform_mode_sel)
            4'h0: begin
                seq = tmc_pkg::SEQ_NORMAL; // [R2]
            end
            4'h1, 4'h2, 4'h3: begin
                seq = tmc_pkg::SEQ_PHASE; // [R3]
                upd_pt = tmc_pkg::PT_TOP;
                ovf_pt = tmc_pkg::PT_BOTTOM;
            end
            4'h4, 4'hC: begin
                seq = tmc_pkg::SEQ_CLEAR_ON_MATCH; // [R5]
                top_src = waveform_mode_sel[3] ? tmc_pkg::TOP_CAPTURE : tmc_pkg::TOP_CMP_A;
            end
            4'h5, 4'h6, 4'h7: begin
                seq = tmc_pkg::SEQ_FAST; // [R4]
                upd_pt = tmc_pkg::PT_BOTTOM;
                ovf_pt = tmc_pkg::PT_TOP;
            end
            4'h8, 4'h9: begin
                seq = tmc_pkg::SEQ_PHASE_FREQ; // [R6]
                upd_pt = tmc_pkg::PT_BOTTOM;
                ovf_pt = tmc_pkg::PT_BOTTOM;
                top_src = waveform_mode_sel[0] ? tmc_pkg::TOP_CMP_A : tmc_pkg::TOP_CAPTURE;
            end
            4'hA, 4'hB: begin
                seq = tmc_pkg::SEQ_PHASE; // [R7]
                upd_pt = tmc_pkg::PT_TOP;
                ovf_pt = tmc_pkg::PT_BOTTOM;
                top_src = waveform_mode_sel[0] ? tmc_pkg::TOP_CMP_A : tmc_pkg::TOP_CAPTURE;
            end
            4'hD: begin
                seq = tmc_pkg::SEQ_RESERVED; // [R9]
                upd_pt = tmc_pkg::PT_NONE;
                ovf_pt = tmc_pkg::PT_NONE;
            end
            4'hE, 4'hF: begin
                seq = tmc_pkg::SEQ_FAST; // [R8]
                upd_pt = tmc_pkg::PT_BOTTOM;
                ovf_pt = tmc_pkg::PT_TOP;
                top_src = waveform_mode_sel[0] ? tmc_pkg::TOP_CMP_A : tmc_pkg::TOP_CAPTURE;
            end
        endcase
        // Fixed-resolution modes share their width code in the low bits.
        unique case (waveform_mode_sel[1:0])
            2'h1: fixed_top = tmc_pkg::TOP_8BIT; // [R3] [R4]
            2'h2: fixed_top = tmc_pkg::TOP_9BIT;
            2'h3: fixed_top = tmc_pkg::TOP_10BIT;
            2'h0: fixed_top = tmc_pkg::CNT_MAX; // [R2]
        endcase
    end

    assign non_pwm = (seq == tmc_pkg::SEQ_NORMAL) || (seq == tmc_pkg::SEQ_CLEAR_ON_MATCH);

    // TOP selection from the fixed value, compare A or the capture register.
    always_comb begin
        unique case (top_src)
            tmc_pkg::TOP_CMP_A: nxt_top = COMPARE_A_VALUE; // [R5] [R6] [R7] [R8]
            tmc_pkg::TOP_CAPTURE: nxt_top = capture_ff; // [R5] [R6] [R7] [R8]
            default: nxt_top = fixed_top;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            top_ff <= tmc_pkg::CNT_MAX;
        end else begin
            top_ff <= nxt_top;
        end
    end

    // Helper controls and their status.
    assign ctl.clk_source_sel = ctrl_b_ff[tmc_pkg::B_CLK_LSB+2:tmc_pkg::B_CLK_LSB]; // [R14]
    assign ctl.capture_filter_en = ctrl_b_ff[tmc_pkg::B_FILTER_BIT]; // [R10]
    assign ctl.capture_edge_sel = ctrl_b_ff[tmc_pkg::B_EDGE_BIT]; // [R11]
    assign ctl.capture_allow = (top_src != tmc_pkg::TOP_CAPTURE); // [R13]

    tmc_prescaler u_presc (
        .clk(CLK),
        .arst_n(ARST_N),
        .ext_count_pin(EXT_COUNT_PIN),
        .ctl(ctl)
    );

    tmc_capture_filter #(
        .SAMPLES(tmc_pkg::FILTER_SAMPLES)
    ) u_capt (
        .clk(CLK),
        .arst_n(ARST_N),
        .capture_pin(CAPTURE_PIN),
        .ctl(ctl)
    );

    assign COUNT_EN = ctl.count_en;

    // Capture copies the live count; a capture in the clearing cycle wins.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_ff <= 16'h0000;
        end else if (ctl.capture_trig) begin
            capture_ff <= COUNT_VALUE; // [R12]
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            capture_flag_ff <= 1'b0;
        end else if (ctl.capture_trig) begin
            capture_flag_ff <= 1'b1; // [R12]
        end else if (CAPTURE_FLAG_CLR) begin
            capture_flag_ff <= 1'b0;
        end
    end

    assign CAPTURE_VALUE = capture_ff;
    assign CAPTURE_FLAG = capture_flag_ff;
    assign CAPTURE_IRQ = capture_flag_ff & CAPTURE_INT_EN; // [R12]

    // Overflow flag point compare value.
    always_comb begin
        unique case (ovf_pt)
            tmc_pkg::PT_TOP: ovf_cmp = top_ff;
            tmc_pkg::PT_BOTTOM: ovf_cmp = tmc_pkg::CNT_BOTTOM;
            default: ovf_cmp = tmc_pkg::CNT_MAX;
        endcase
    end

    // Overflow and clear pulses come from counted ticks only, never from a force strobe.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ovf_ff <= 1'b0;
            clear_ff <= 1'b0;
        end else begin
            ovf_ff <= COUNT_EN && (ovf_pt != tmc_pkg::PT_NONE) && (COUNT_VALUE == ovf_cmp); // [R2] [R5]
            clear_ff <= COUNT_EN && (seq == tmc_pkg::SEQ_CLEAR_ON_MATCH) && (COUNT_VALUE == top_ff); // [R18]
        end
    end

    assign OVERFLOW_SET = ovf_ff;
    assign COUNTER_CLEAR = clear_ff;
    assign TOP_VALUE = top_ff;
    assign COUNT_SEQ = seq;
    assign BUF_UPDATE_POINT = upd_pt;
    assign OVERFLOW_POINT = ovf_pt;

    // Force strobes from a write to control C, dropped in PWM modes.
    generate
        for (genvar ch = 0; ch < 3; ch++) begin : g_chan
            logic [1:0] action;
            logic out_ff;
            assign force_match[ch] = IO_WR && hit_c && non_pwm &&
                                     IO_WDATA[tmc_pkg::C_FORCE_A_BIT-ch]; // [R16] [R17]
            assign action = ctrl_a_ff[tmc_pkg::A_ACTION_A_LSB-2*ch+1:tmc_pkg::A_ACTION_A_LSB-2*ch];
            assign COMPARE_CONN[ch] = (action != tmc_pkg::ACT_OFF); // [R23]

            // Action is read at the strobe itself; PWM shaping lies elsewhere.
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    out_ff <= 1'b0;
                end else if (non_pwm && (force_match[ch] || (MATCH[ch] && COUNT_EN))) begin
                    unique case (action) // [R17] [R23]
                        tmc_pkg::ACT_TOGGLE: out_ff <= ~out_ff;
                        tmc_pkg::ACT_CLEAR: out_ff <= 1'b0;
                        tmc_pkg::ACT_SET: out_ff <= 1'b1;
                        tmc_pkg::ACT_OFF: out_ff <= out_ff;
                    endcase
                end
            end
            assign COMPARE_OUT[ch] = out_ff;
        end
    endgenerate
endmodule : tmc_mode_ctrl

/* File: tmc_pins_model.sv */
`timescale 1ns/10ps
// Pin side of the timer: capture pin and the external count pin.
module tmc_pins_model (
    input wire logic clk,
    input wire logic cap_lvl,
    input wire logic run,
    output logic capture_pin,
    output logic ext_count_pin
);
    logic [1:0] ph_ff;

    // Start from a known level so the first counted edge is a real one.
    initial begin
        ph_ff = 2'h0;
        ext_count_pin = 1'b0;
        capture_pin = 1'b1;
    end

    // Count pin driven as an output, toggling every 4 cycles while run is high.
    always @(posedge clk) begin
        capture_pin <= cap_lvl;
        if (run) begin
            ph_ff <= ph_ff + 2'h1;
            if (ph_ff == 2'h3) ext_count_pin <= ~ext_count_pin;
        end
    end
endmodule : tmc_pins_model

/* File: tmc_mode_ctrl_props.sv */
`timescale 1ns/10ps
// Port-level relations of the mode control, all in the one clock domain.
module tmc_mode_ctrl_props (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic IO_RD,
    input wire logic IO_HIT,
    input wire logic [7:0] IO_RDATA,
    input wire logic [15:0] COUNT_VALUE,
    input wire logic COUNT_EN,
    input wire logic [15:0] TOP_VALUE,
    input wire logic [2:0] COUNT_SEQ,
    input wire logic [2:0] BUF_UPDATE_POINT,
    input wire logic [2:0] OVERFLOW_POINT,
    input wire logic OVERFLOW_SET,
    input wire logic COUNTER_CLEAR,
    input wire logic [15:0] CAPTURE_VALUE,
    input wire logic CAPTURE_FLAG,
    input wire logic CAPTURE_INT_EN,
    input wire logic CAPTURE_IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    a_normal_points: assert property (COUNT_SEQ == 3'h0 |-> BUF_UPDATE_POINT == 3'h0 && OVERFLOW_POINT == 3'h3)
        else $error("normal mode points wrong");
    a_ctc_points: assert property (COUNT_SEQ == 3'h1 |-> BUF_UPDATE_POINT == 3'h0 && OVERFLOW_POINT == 3'h3)
        else $error("clear on match points wrong");
    a_fast_points: assert property (COUNT_SEQ == 3'h2 |-> BUF_UPDATE_POINT == 3'h2 && OVERFLOW_POINT == 3'h1)
        else $error("fast pwm points wrong");
    a_phase_points: assert property (COUNT_SEQ == 3'h3 |-> BUF_UPDATE_POINT == 3'h1 && OVERFLOW_POINT == 3'h2)
        else $error("phase correct points wrong");
    a_pfc_points: assert property (COUNT_SEQ == 3'h4 |-> BUF_UPDATE_POINT == 3'h2 && OVERFLOW_POINT == 3'h2)
        else $error("phase frequency points wrong");
    a_clear_cause: assert property (COUNTER_CLEAR |-> $past(COUNT_EN) && $past(COUNT_SEQ) == 3'h1 && $past(COUNT_VALUE) == $past(TOP_VALUE))
        else $error("counter clear without a counted match");
    a_overflow_cause: assert property (OVERFLOW_SET |-> $past(COUNT_EN) && ($past(OVERFLOW_POINT) != 3'h3 || $past(COUNT_VALUE) == 16'hFFFF))
        else $error("overflow without a tick at its point");
    a_capture_copy: assert property ($rose(CAPTURE_FLAG) |-> CAPTURE_VALUE == $past(COUNT_VALUE))
        else $error("capture value is not the counter value");
    a_irq_gate: assert property (CAPTURE_IRQ == (CAPTURE_FLAG && CAPTURE_INT_EN))
        else $error("capture request not gated by enable");
    a_unmapped_read: assert property (IO_RD && !IO_HIT |=> IO_RDATA == 8'h00)
        else $error("unmapped read not zero");
endmodule : tmc_mode_ctrl_props

bind tmc_mode_ctrl tmc_mode_ctrl_props chk_u (.*);

/* File: tmc_mode_ctrl_test.sv */
`timescale 1ns/10ps
// Bench for timer unit 1.
module tmc_mode_ctrl_test;
    logic CLK = 1'b0, ARST_N = 1'b0, IO_SPACE = 1'b1, IO_WR = 1'b0, IO_RD = 1'b0, pend = 1'b0;
    logic CAPTURE_FLAG_CLR = 1'b0, CAPTURE_INT_EN = 1'b0, cap_lvl = 1'b1, run = 1'b0;
    logic [7:0] IO_ADDR = 8'h00, IO_WDATA = 8'h00, IO_RDATA, d;
    logic [15:0] COUNT_VALUE = 16'hFFF0, COMPARE_A_VALUE = 16'h0000, TOP_VALUE, CAPTURE_VALUE;
    logic [2:0] MATCH = 3'h0, COUNT_SEQ, BUF_UPDATE_POINT, OVERFLOW_POINT, COMPARE_OUT, COMPARE_CONN;
    logic CAPTURE_PIN, EXT_COUNT_PIN, IO_HIT, COUNT_EN, OVERFLOW_SET, COUNTER_CLEAR, CAPTURE_FLAG, CAPTURE_IRQ;
    logic [63:0] seq_tab = 64'h2251_3344_2221_3330;
    logic [63:0] src_tab = 64'h1202_1212_0001_0000;
    logic [7:0] rd_q[$];
    int num_errors = 0, tests_run = 0, seed = 77, n;
    int div_exp[8] = '{0, 1024, 128, 16, 4, 1, 8, 8};

    tmc_mode_ctrl dut_u (.*);
    tmc_pins_model pins_u (.clk(CLK), .cap_lvl(cap_lvl), .run(run), .capture_pin(CAPTURE_PIN),
                           .ext_count_pin(EXT_COUNT_PIN));

    // Clock and a stand-in counter.
    always #10 CLK = ~CLK;
    always @(posedge CLK) COUNT_VALUE <= COUNT_VALUE + 16'h0001;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask : chk_rd

    // One access; a read queues its expected data.
    task automatic acc(input logic wr, input logic sp, input logic [7:0] a, input logic [7:0] v);
        @(posedge CLK);
        IO_SPACE <= sp;
        IO_ADDR <= a;
        IO_WDATA <= v;
        IO_WR <= wr;
        IO_RD <= ~wr;
        if (!wr) rd_q.push_back(v);
        @(posedge CLK);
        IO_WR <= 1'b0;
        IO_RD <= 1'b0;
    endtask : acc

    task automatic cyc(input int k);
        repeat (k) @(posedge CLK);
    endtask : cyc

    // Pulse the flag clear, then check it stays low.
    task automatic clr_flag();
        @(posedge CLK);
        CAPTURE_FLAG_CLR <= 1'b1;
        @(posedge CLK);
        CAPTURE_FLAG_CLR <= 1'b0;
        cyc(1);
        chk({15'h0000, CAPTURE_FLAG}, 16'h0000);
    endtask : clr_flag

    task automatic final_report();
        if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report

    // Registered read data is compared one cycle after the read.
    always @(posedge CLK) begin
        if (pend) chk_rd(IO_RDATA, rd_q.pop_front());
        pend <= IO_RD;
    end

    // Watchdog well past the longest run.
    initial begin
        #1_000_000;
        num_errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        acc(0, 1, 8'h2E, 8'h00);
        acc(0, 0, 8'h7A, 8'h00);
        d = 8'($random(seed));
        acc(1, 1, 8'h2E, d);
        acc(1, 1, 8'h4E, 8'hFF);
        acc(0, 0, 8'h4E, d & 8'hDF);
        acc(0, 1, 8'h7A, 8'h00);
        COMPARE_A_VALUE <= 16'($random(seed));
        for (int m = 0; m < 16; m++) begin
            if (m == 13) continue; // The reserved mode is never selected.
            acc(1, 1, 8'h2F, {6'h00, m[1:0]});
            acc(1, 0, 8'h4E, {3'h0, m[3:2], 3'h1});
            cyc(2);
            chk({13'h0000, COUNT_SEQ}, {13'h0000, seq_tab[4*m +: 3]});
            chk(TOP_VALUE, src_tab[4*m +: 2] == 2'h1 ? COMPARE_A_VALUE : src_tab[4*m +: 2] == 2'h2 ? 16'h0000 :
                m[1:0] == 2'h0 ? 16'hFFFF : 16'h03FF >> (2'h3 - m[1:0]));
        end
        acc(1, 1, 8'h2F, 8'h00);
        for (int c = 0; c < 8; c++) begin
            acc(1, 1, 8'h2E, 8'(c));
            run <= (c > 5);
            n = 0;
            for (int k = 0; k < 1024; k++) begin
                @(posedge CLK);
                if (k == 63) run <= 1'b0;
                n += (COUNT_EN === 1'b1);
            end
            chk(16'(n), 16'(div_exp[c]));
        end
        for (int i = 0; i < 4; i++) begin
            CAPTURE_INT_EN <= 1'($random(seed));
            acc(1, 1, 8'h2E, {i[1], i[0], 6'h01});
            cap_lvl <= ~i[0];
            cyc(12);
            clr_flag();
            cap_lvl <= i[0];
            n = 0;
            while (CAPTURE_FLAG !== 1'b1 && n < 14) begin
                @(posedge CLK);
                n++;
            end
            chk(16'(i[1] ? (n >= 6 && n <= 11) : (n >= 3 && n <= 5)), 16'h0001);
            clr_flag();
            cap_lvl <= ~i[0];
            cyc(12);
            chk({15'h0000, CAPTURE_FLAG}, 16'h0000);
        end
        acc(1, 1, 8'h2E, 8'h59);
        cap_lvl <= 1'b1;
        cyc(12);
        chk({15'h0000, CAPTURE_FLAG}, 16'h0000);
        COMPARE_A_VALUE <= 16'h0000;
        acc(1, 1, 8'h2E, 8'h09);
        for (int j = 0; j < 4; j++) begin
            d = (j == 0 || j == 3) ? 8'h40 : (j == 1 ? 8'h80 : 8'hC0);
            acc(1, 1, 8'h2F, d);
            acc(1, 0, 8'h7A, 8'h80);
            cyc(1);
            chk({15'h0000, COMPARE_OUT[0]}, 16'(j == 0 || j == 2));
            chk({15'h0000, COUNTER_CLEAR | CAPTURE_IRQ}, 16'h0000);
            chk({15'h0000, COMPARE_CONN[0]}, 16'h0001);
        end
        acc(1, 1, 8'h2F, 8'h41);
        acc(1, 0, 8'h7A, 8'hE0);
        cyc(1);
        chk({15'h0000, COMPARE_OUT[0]}, 16'h0000);
        acc(0, 0, 8'h7A, 8'h00);
        acc(1, 1, 8'h2F, 8'h00);
        COMPARE_A_VALUE <= COUNT_VALUE + 16'h0010;
        n = 0;
        while (COUNTER_CLEAR !== 1'b1 && n < 40) begin
            @(posedge CLK);
            n++;
        end
        chk({15'h0000, COUNTER_CLEAR}, 16'h0001);
        cyc(2);
        final_report();
    end
endmodule : tmc_mode_ctrl_test
